// ---- hdl/smb_side_dev.sv ----
// Notes on behaviour
// - Controller drives suspend low entering suspend.
// - Suspend line returns high on resume.
// - Suspend is a driven, unshared controller output.
// - No bus traffic during suspend except wake.
// - Suspend only after STOP, never mid-message.
// - No new message before resume completes.
// - Powered bus: START while suspended starts resume.
// - Both lines high outside a frame means bus idle.
// - Resume on START for unsuspendable masters.
// - Suspend behaviour configured during normal operation.
// - Alert is open-drain wired-AND like clock, data.
// - Host answers alert by reading response address.
// - Acknowledge response address only while pulling alert.
// - Return own 7-bit address in upper bits.
// - PEC frame: address byte, ack, PEC, STOP.
// - Lowest address wins arbitration; losers stop sending.
// - Release alert once address byte sent, ACKed or NACKed.
// - Host rereads response address if alert still low.
// - Host without alert line polls periodically.
// - Alert messages carry two bytes, three with PEC.
`timescale 1ns/1ps
`default_nettype none
`include "smb_side_params.svh"

module smb_side_dev
	import smb_side_pkg::*;
(
	input wire logic linkClk,
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sleepReq,
	input wire logic wakeOnStart,
	input wire logic alertReq,
	input wire logic pecEn,
	input wire smb_side_pkg::addr_t myAddr,
	output logic suspended,
	output logic alertActive,
	output logic busIdle,
	output logic alertServed,
	smb_side_if.dev busif
);
	import smb_side_pkg::*;

	logic [6:0] linkS;
	logic rstLinkN;
	logic sleepS;
	logic wakeS;
	logic alertReqS;
	logic pecS;
	logic sclS;
	logic sdaS;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic araMatch;
	byte_t loadByte;
	addr_t myAddrS;

	devState_t state_reg, state_next;
	logic [3:0] bitCnt_reg, bitCnt_next;
	byte_t shift_reg, shift_next;
	byte_t crc_reg, crc_next;
	addr_t addr_reg, addr_next;
	logic pecPhase_reg, pecPhase_next;
	logic sdaOe_reg, sdaOe_next;
	logic alertOe_reg, alertOe_next;
	logic susN_reg, susN_next;
	logic inFrame_reg, inFrame_next;
	logic wakeHold_reg, wakeHold_next;
	logic wakeCfg_reg, wakeCfg_next;
	logic pecCfg_reg, pecCfg_next;
	logic servedTgl_reg, servedTgl_next;
	logic idle_reg, idle_next;
	logic sclD_reg, sdaD_reg, alertReqD_reg;

	logic [3:0] sysS;
	logic servedD_reg, servedPulse_reg, servedPulse_next;

	// Everything from outside the link domain passes two flops first
	smb_sync #(.W(7)) linkSync (
		.clk(linkClk),
		.din({rst_n, sleepReq, wakeOnStart, alertReq, pecEn,
			busif.scl, busif.sda}),
		.dout(linkS)
	);

	// Address is synced as deep as its strobe, so both land together
	smb_sync #(.W(7)) addrSync (
		.clk(linkClk),
		.din(myAddr),
		.dout(myAddrS)
	);

	assign {rstLinkN, sleepS, wakeS, alertReqS, pecS, sclS, sdaS} = linkS;

	// Bus events seen on the synchronised lines
	assign sclRise = sclS & ~sclD_reg;
	assign sclFall = ~sclS & sclD_reg;
	assign startSeen = sclS & sclD_reg & sdaD_reg & ~sdaS;
	assign stopSeen = sclS & sclD_reg & ~sdaD_reg & sdaS;
	assign araMatch = (shift_reg == {`SMB_ARA_ADDR, `SMB_RD_BIT});
	assign loadByte = pecPhase_reg ? crc_reg : {addr_reg, 1'b1};

	// Link-side next state: suspend control, frame tracking, alert reply
	always_comb begin
		state_next = state_reg;
		bitCnt_next = bitCnt_reg;
		shift_next = shift_reg;
		crc_next = crc_reg;
		addr_next = addr_reg;
		pecPhase_next = pecPhase_reg;
		sdaOe_next = sdaOe_reg;
		alertOe_next = alertOe_reg;
		susN_next = susN_reg;
		inFrame_next = inFrame_reg;
		wakeHold_next = wakeHold_reg;
		wakeCfg_next = wakeCfg_reg;
		pecCfg_next = pecCfg_reg;
		servedTgl_next = servedTgl_reg;
		idle_next = sclS & sdaS & ~inFrame_reg;

		if (startSeen) begin
			inFrame_next = 1'b1;
		end else if (stopSeen) begin
			inFrame_next = 1'b0;
		end

		// Options are only taken while the system runs normally
		if (susN_reg) begin
			wakeCfg_next = wakeS;
			pecCfg_next = pecS;
		end

		if (!sleepS) begin
			wakeHold_next = 1'b0;
		end
		if (susN_reg) begin
			// Only between messages, so never cut a frame in two
			if (sleepS && !wakeHold_reg && !inFrame_reg && !startSeen) begin
				susN_next = 1'b0;
			end
		end else if (!sleepS) begin
			susN_next = 1'b1;
		end else if (wakeCfg_reg && startSeen) begin
			// Held awake until the request drops, else STOP re-suspends
			susN_next = 1'b1;
			wakeHold_next = 1'b1;
		end

		unique case (state_reg)
			D_IDLE: begin
			end
			D_ADDR: begin
				if (sclRise) begin
					shift_next = {shift_reg[6:0], sdaS};
					crc_next = crc8Step(crc_reg, sdaS);
					bitCnt_next = bitCnt_reg + 4'h1;
				end else if (sclFall && bitCnt_reg == `SMB_BYTE_BITS) begin
					// Silent while suspended: no traffic but the wake
					if (araMatch && alertOe_reg && susN_reg) begin
						sdaOe_next = 1'b1;
						state_next = D_ACK;
					end else begin
						state_next = D_WAIT;
					end
				end
			end
			D_ACK: begin
				if (sclFall) begin
					shift_next = loadByte;
					bitCnt_next = 4'h0;
					sdaOe_next = ~loadByte[7];
					state_next = D_TX;
				end
			end
			D_TX: begin
				if (sclRise) begin
					bitCnt_next = bitCnt_reg + 4'h1;
					if (!pecPhase_reg) begin
						crc_next = crc8Step(crc_reg, sdaS);
					end
					// Sent a one, saw a zero: a lower address is talking
					if (shift_reg[7] && !sdaS) begin
						sdaOe_next = 1'b0;
						state_next = D_WAIT;
					end
				end else if (sclFall) begin
					if (bitCnt_reg == `SMB_BYTE_BITS) begin
						sdaOe_next = 1'b0;
						state_next = D_RACK;
					end else begin
						shift_next = {shift_reg[6:0], 1'b0};
						sdaOe_next = ~shift_reg[6];
					end
				end
			end
			D_RACK: begin
				if (sclRise) begin
					state_next = D_WAIT;
					// Reply byte went out whole; a plain read ends on a NACK
					if (!pecPhase_reg) begin
						alertOe_next = 1'b0;
						servedTgl_next = ~servedTgl_reg;
						if (pecCfg_reg && !sdaS) begin
							pecPhase_next = 1'b1;
							state_next = D_ACK;
						end
					end
				end
			end
			D_WAIT: begin
			end
		endcase

		// A START restarts reception, a STOP ends any frame
		if (startSeen) begin
			state_next = D_ADDR;
			bitCnt_next = 4'h0;
			crc_next = `SMB_CRC_INIT;
			pecPhase_next = 1'b0;
			sdaOe_next = 1'b0;
		end else if (stopSeen) begin
			state_next = D_IDLE;
			sdaOe_next = 1'b0;
		end

		// New alert last, so a request wins over a same-cycle release
		if (alertReqS && !alertReqD_reg) begin
			alertOe_next = 1'b1;
			addr_next = myAddrS; // Held stable by contract while high
		end
	end

	// Link-side registers
	always_ff @(posedge linkClk) begin
		sclD_reg <= sclS;
		sdaD_reg <= sdaS;
		alertReqD_reg <= alertReqS;
		if (!rstLinkN) begin
			state_reg <= D_IDLE;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			crc_reg <= `SMB_CRC_INIT;
			addr_reg <= `SMB_ADDR_RST;
			pecPhase_reg <= 1'b0;
			sdaOe_reg <= 1'b0;
			alertOe_reg <= 1'b0;
			susN_reg <= 1'b1;
			inFrame_reg <= 1'b0;
			wakeHold_reg <= 1'b0;
			wakeCfg_reg <= 1'b0;
			pecCfg_reg <= 1'b0;
			servedTgl_reg <= 1'b0;
			idle_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bitCnt_reg <= bitCnt_next;
			shift_reg <= shift_next;
			crc_reg <= crc_next;
			addr_reg <= addr_next;
			pecPhase_reg <= pecPhase_next;
			sdaOe_reg <= sdaOe_next;
			alertOe_reg <= alertOe_next;
			susN_reg <= susN_next;
			inFrame_reg <= inFrame_next;
			wakeHold_reg <= wakeHold_next;
			wakeCfg_reg <= wakeCfg_next;
			pecCfg_reg <= pecCfg_next;
			servedTgl_reg <= servedTgl_next;
			idle_reg <= idle_next;
		end
	end

	// Dedicated, actively driven suspend output
	assign busif.suspendN = susN_reg;
	assign busif.devSdaOe = sdaOe_reg;
	assign busif.devAlertOe = alertOe_reg;

	// Status back to the system clock; served crosses as a toggle
	smb_sync #(.W(4)) sysSync (
		.clk(clk_sys),
		.din({idle_reg, servedTgl_reg, alertOe_reg, ~susN_reg}),
		.dout(sysS)
	);

	assign servedPulse_next = sysS[2] ^ servedD_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			servedD_reg <= 1'b0;
			servedPulse_reg <= 1'b0;
		end else begin
			servedD_reg <= sysS[2];
			servedPulse_reg <= servedPulse_next;
		end
	end

	assign suspended = sysS[0];
	assign alertActive = sysS[1];
	assign busIdle = sysS[3];
	assign alertServed = servedPulse_reg;
endmodule

`default_nettype wire

// ---- hdl/smb_side_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smb_side_params.svh"

module smb_side_host
	import smb_side_pkg::*;
#(
	parameter int POLL_CYC = `SMB_POLL_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pecEn,
	input wire logic pollEn,
	input wire logic wakeReq,
	output logic busy,
	output smb_side_pkg::addr_t respAddr,
	output logic respValid,
	output logic pecErr,
	output logic noResp,
	smb_side_if.host busif
);
	import smb_side_pkg::*;

	localparam int QUARTER = `SMB_QUARTER_CYC;
	localparam int PW = $clog2(POLL_CYC + 1);

	logic [2:0] hostS;
	logic sdaS, alertLowS, susS;
	logic tick;
	logic pollDue;

	hostState_t state_reg, state_next;
	logic [7:0] qCnt_reg, qCnt_next;
	logic [1:0] phase_reg, phase_next;
	logic [3:0] bitIdx_reg, bitIdx_next;
	logic [1:0] byteIdx_reg, byteIdx_next;
	logic sclOe_reg, sclOe_next, sdaOe_reg, sdaOe_next;
	byte_t shift_reg, shift_next, crc_reg, crc_next;
	logic [PW-1:0] pollCnt_reg, pollCnt_next;
	logic wakeOnly_reg, wakeOnly_next, pecOn_reg, pecOn_next;
	logic done_reg, done_next;
	addr_t addr_reg, addr_next;
	logic valid_reg, valid_next, err_reg, err_next, nack_reg, nack_next;

	smb_sync #(.W(3)) hostSync (
		.clk(clk_sys),
		.din({busif.sda, ~busif.alertN, busif.suspendN}),
		.dout(hostS)
	);

	assign {sdaS, alertLowS, susS} = hostS;
	assign tick = (qCnt_reg == 8'(QUARTER - 1));
	assign pollDue = pollEn && (pollCnt_reg == PW'(POLL_CYC - 1));

	// Bit engine: four quarters per bit, SCL low in quarters 0 and 1
	always_comb begin
		state_next = state_reg;
		qCnt_next = tick ? 8'h00 : qCnt_reg + 8'h01;
		phase_next = phase_reg;
		bitIdx_next = bitIdx_reg;
		byteIdx_next = byteIdx_reg;
		sclOe_next = sclOe_reg;
		sdaOe_next = sdaOe_reg;
		shift_next = shift_reg;
		crc_next = crc_reg;
		pollCnt_next = pollEn ? pollCnt_reg + PW'(1) : '0;
		wakeOnly_next = wakeOnly_reg;
		pecOn_next = pecOn_reg;
		done_next = done_reg;
		addr_next = addr_reg;
		valid_next = 1'b0;
		err_next = err_reg;
		nack_next = 1'b0;
		if (pollDue) begin
			pollCnt_next = '0;
		end
		unique case (state_reg)
			H_IDLE: begin
				qCnt_next = 8'h00;
				phase_next = 2'h0;
				// No message while suspended, only the wake START
				if (susS && (alertLowS || pollDue)) begin
					state_next = H_START;
					wakeOnly_next = 1'b0;
				end else if (!susS && wakeReq) begin
					state_next = H_START;
					wakeOnly_next = 1'b1;
				end
				if (state_next == H_START) begin
					sdaOe_next = 1'b1;
					shift_next = {`SMB_ARA_ADDR, `SMB_RD_BIT};
					crc_next = `SMB_CRC_INIT;
					pecOn_next = pecEn;
					done_next = 1'b0;
					bitIdx_next = 4'h0;
					byteIdx_next = 2'h0;
				end
			end
			H_START: begin
				if (tick) begin
					sclOe_next = 1'b1;
					state_next = wakeOnly_reg ? H_STOP : H_XFER;
				end
			end
			H_XFER: begin
				if (tick) begin
					phase_next = phase_reg + 2'h1;
					unique case (phase_reg)
						2'h0: begin
							if (bitIdx_reg < `SMB_BYTE_BITS) begin
								sdaOe_next = (byteIdx_reg == 2'h0) & ~shift_reg[7];
							end else begin
								// Ack the address byte only when a PEC follows
								sdaOe_next = (byteIdx_reg == 2'h1) & pecOn_reg;
							end
						end
						2'h1: sclOe_next = 1'b0;
						2'h2: begin
							if (bitIdx_reg < `SMB_BYTE_BITS) begin
								shift_next = {shift_reg[6:0], sdaS};
								if (byteIdx_reg != 2'h2) begin
									crc_next = crc8Step(crc_reg, sdaS);
								end
							end else if (byteIdx_reg == 2'h0) begin
								done_next = sdaS;
								nack_next = sdaS;
							end else if (byteIdx_reg == 2'h1) begin
								addr_next = shift_reg[7:1];
								valid_next = 1'b1;
								err_next = 1'b0;
								done_next = ~pecOn_reg;
							end else begin
								err_next = (shift_reg != crc_reg);
								done_next = 1'b1;
							end
						end
						2'h3: begin
							sclOe_next = 1'b1;
							if (bitIdx_reg == `SMB_BYTE_BITS) begin
								bitIdx_next = 4'h0;
								byteIdx_next = byteIdx_reg + 2'h1;
								if (done_reg) begin
									state_next = H_STOP;
								end
							end else begin
								bitIdx_next = bitIdx_reg + 4'h1;
							end
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					phase_next = phase_reg + 2'h1;
					unique case (phase_reg)
						2'h0: sdaOe_next = 1'b1;
						2'h1: sclOe_next = 1'b0;
						2'h2: sdaOe_next = 1'b0;
						2'h3: state_next = H_IDLE;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= H_IDLE;
			qCnt_reg <= 8'h00;
			phase_reg <= 2'h0;
			bitIdx_reg <= 4'h0;
			byteIdx_reg <= 2'h0;
			sclOe_reg <= 1'b0;
			sdaOe_reg <= 1'b0;
			shift_reg <= 8'h00;
			crc_reg <= `SMB_CRC_INIT;
			pollCnt_reg <= '0;
			wakeOnly_reg <= 1'b0;
			pecOn_reg <= 1'b0;
			done_reg <= 1'b0;
			addr_reg <= `SMB_ADDR_RST;
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			qCnt_reg <= qCnt_next;
			phase_reg <= phase_next;
			bitIdx_reg <= bitIdx_next;
			byteIdx_reg <= byteIdx_next;
			sclOe_reg <= sclOe_next;
			sdaOe_reg <= sdaOe_next;
			shift_reg <= shift_next;
			crc_reg <= crc_next;
			pollCnt_reg <= pollCnt_next;
			wakeOnly_reg <= wakeOnly_next;
			pecOn_reg <= pecOn_next;
			done_reg <= done_next;
			addr_reg <= addr_next;
			valid_reg <= valid_next;
			err_reg <= err_next;
			nack_reg <= nack_next;
		end
	end

	assign busif.hostSclOe = sclOe_reg;
	assign busif.hostSdaOe = sdaOe_reg;
	assign busy = (state_reg != H_IDLE);
	assign respAddr = addr_reg;
	assign respValid = valid_reg;
	assign pecErr = err_reg;
	assign noResp = nack_reg;
endmodule

`default_nettype wire

// ---- hdl/smb_side_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface smb_side_if;
	logic suspendN;
	logic hostSclOe;
	logic hostSdaOe;
	logic devSdaOe;
	logic devAlertOe;
	logic scl;
	logic sda;
	logic alertN;

	// Open-drain wires: any enabled driver pulls low
	assign scl = ~hostSclOe;
	assign sda = ~(hostSdaOe | devSdaOe);
	assign alertN = ~devAlertOe;

	modport dev (
		output suspendN,
		output devSdaOe,
		output devAlertOe,
		input scl,
		input sda,
		input alertN
	);

	modport host (
		output hostSclOe,
		output hostSdaOe,
		input scl,
		input sda,
		input alertN,
		input suspendN
	);
endinterface

`default_nettype wire

// ---- hdl/smb_side_params.svh ----
`ifndef SMB_SIDE_PARAMS_SVH
`define SMB_SIDE_PARAMS_SVH

// System clock period in ns
`define SMB_SYS_PERIOD_NS 100
// Quarter of one bus bit time in ns (100 kHz bus clock)
`define SMB_QUARTER_NS 2500
// Least time, so round up to whole system cycles
`define SMB_QUARTER_CYC \
	((`SMB_QUARTER_NS + `SMB_SYS_PERIOD_NS - 1) / `SMB_SYS_PERIOD_NS)
// Period of alert polling in us
`define SMB_POLL_US 10000
`define SMB_POLL_CYC ((`SMB_POLL_US * 1000) / `SMB_SYS_PERIOD_NS)
// Alert response address (7 bit) and read direction bit
`define SMB_ARA_ADDR 7'h0c
`define SMB_RD_BIT 1'b1
// Packet error code polynomial x^8 + x^2 + x + 1
`define SMB_CRC_POLY 8'h07
// Reset values
`define SMB_CRC_INIT 8'h00
`define SMB_ADDR_RST 7'h00
// Bits of one byte and index of its acknowledge slot
`define SMB_BYTE_BITS 4'h8

`endif

// ---- hdl/smb_side_pkg.sv ----
`default_nettype none
`include "smb_side_params.svh"

package smb_side_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [6:0] addr_t;

	typedef enum logic [2:0] {
		D_IDLE,
		D_ADDR,
		D_ACK,
		D_TX,
		D_RACK,
		D_WAIT
	} devState_t;

	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_XFER,
		H_STOP
	} hostState_t;

	// One bit of the packet error code, MSB first
	function automatic byte_t crc8Step(input byte_t crc, input logic b);
		logic fb;
		fb = crc[7] ^ b;
		crc8Step = {crc[6:0], 1'b0} ^ (fb ? `SMB_CRC_POLY : 8'h00);
	endfunction

endpackage

`default_nettype wire

// ---- hdl/smb_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module smb_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1_reg;

	// Two flops per bit; only the second stage is ever read
	always_ff @(posedge clk) begin
		stage1_reg <= din;
		dout <= stage1_reg;
	end
endmodule

`default_nettype wire

// ---- tb/smb_side_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module smb_side_assertions (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic suspendN,
	input wire logic hostSclOe,
	input wire logic hostSdaOe,
	input wire logic devSdaOe,
	input wire logic devAlertOe,
	input wire logic scl,
	input wire logic sda,
	input wire logic alertN
);
	logic sclQ, sdaQ, openReg, openNext, startSeen;

	// START: data falls while clock stays high
	assign startSeen = scl && sclQ && sdaQ && !sda;

	// Frame tracking from the resolved wires, not from either end
	always_comb begin
		openNext = openReg;
		if (startSeen)
			openNext = 1'b1;
		else if (scl && sclQ && !sdaQ && sda)
			openNext = 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		sclQ <= scl;
		sdaQ <= sda;
		openReg <= rst_n ? openNext : 1'b0;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	suspend_bus_quiet_a: assert property (
		!suspendN |-> !hostSclOe && !devSdaOe) else $error("bus driven in suspend");
	suspend_after_stop_a: assert property (
		$fell(suspendN) |-> !openReg && !hostSdaOe) else $error("suspend mid frame");
	clock_in_frame_a: assert property (
		hostSclOe |-> openReg) else $error("clock pulled outside a frame");
	wake_on_start_a: assert property (
		startSeen && !suspendN |-> ##[1:80] suspendN) else $error("no resume");
	alert_service_a: assert property (
		$fell(alertN) && suspendN && !openReg |-> ##[1:4] openReg)
		else $error("alert not serviced");
	dev_in_frame_a: assert property (
		devSdaOe |-> openReg) else $error("device drives data outside frame");
	dev_data_edge_a: assert property (
		$changed(devSdaOe) |-> !scl) else $error("device data moved with clock high");
	alert_release_a: assert property (
		$fell(devAlertOe) |-> openReg) else $error("alert released outside frame");

	cover property ($fell(devAlertOe));
	cover property ($rose(suspendN));
	cover property (startSeen && !suspendN);
endmodule

`default_nettype wire

// ---- tb/test_smbus_alert_suspend_sideband.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smb_side_params.svh"

module test_smbus_alert_suspend_sideband;
	import smb_side_pkg::*;
	logic clk_sys, linkClk, rst_n, sclQ, sdaQ;
	logic sleepReq, wakeOnStart, alertReq, pecEn, pollEn, wakeReq;
	logic suspended, alertActive, busIdle, alertServed;
	logic busy, respValid, pecErr, noResp;
	addr_t myAddr, respAddr;
	int num_errors, check_count, cycles, nRsp, nNack, nSrv, nBits;
	logic bitLog [0:31];

	smb_side_if busIf();
	smb_side_dev smb_side_dev_inst (.linkClk(linkClk), .clk_sys(clk_sys),
		.rst_n(rst_n), .sleepReq(sleepReq), .wakeOnStart(wakeOnStart),
		.alertReq(alertReq), .pecEn(pecEn), .myAddr(myAddr),
		.suspended(suspended), .alertActive(alertActive), .busIdle(busIdle),
		.alertServed(alertServed), .busif(busIf.dev));
	// Short poll period keeps the polling test within the run budget
	smb_side_host #(.POLL_CYC(500)) smb_side_host_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .pecEn(pecEn), .pollEn(pollEn), .wakeReq(wakeReq),
		.busy(busy), .respAddr(respAddr), .respValid(respValid),
		.pecErr(pecErr), .noResp(noResp), .busif(busIf.host));
	smb_side_assertions smb_side_assertions_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .suspendN(busIf.suspendN), .hostSclOe(busIf.hostSclOe),
		.hostSdaOe(busIf.hostSdaOe), .devSdaOe(busIf.devSdaOe),
		.devAlertOe(busIf.devAlertOe), .scl(busIf.scl), .sda(busIf.sda),
		.alertN(busIf.alertN));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Odd offset so link edges drift against the system clock
	initial begin
		linkClk = 1'b0;
		#37;
		forever #80 linkClk = ~linkClk;
	end

	// Pulse counters, wire bit log taken at each clock rise, hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		sclQ <= busIf.scl;
		sdaQ <= busIf.sda;
		if (respValid === 1'b1) nRsp <= nRsp + 1;
		if (noResp === 1'b1) nNack <= nNack + 1;
		if (alertServed === 1'b1) nSrv <= nSrv + 1;
		if (busIf.scl && sclQ && sdaQ && !busIf.sda) nBits <= 0;
		else if (busIf.scl && !sclQ) begin
			bitLog[nBits[4:0]] <= busIf.sda;
			nBits <= nBits + 1;
		end
		if (cycles > 60000) begin
			num_errors = num_errors + 1;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic waitCnt(ref int c, input int want);
		int i = 0;
		while (c < want && i < 8000) begin
			@(posedge clk_sys);
			i++;
		end
		chk("pulse seen", 8'h01, {7'h0, c >= want});
	endtask
	task automatic waitSus(input logic v);
		int i = 0;
		while (suspended !== v && i < 2000) begin
			@(posedge clk_sys);
			i++;
		end
		chk("suspended", {7'h0, v}, {7'h0, suspended});
	endtask
	task automatic waitIdle();
		int i = 0;
		while (busy !== 1'b0 && i < 4000) begin
			@(posedge clk_sys);
			i++;
		end
		chk("host idle", 8'h00, {7'h0, busy});
	endtask
	function automatic byte_t pick(input int s);
		byte_t b;
		for (int k = 0; k < 8; k++) b[7-k] = bitLog[s+k];
		return b;
	endfunction

	// Decode the logged frame; STOP adds one rise; CRC rebuilt MSB first
	task automatic chkFrame(input addr_t a, input logic pec);
		byte_t crc, r;
		logic [15:0] msg;
		msg = {`SMB_ARA_ADDR, `SMB_RD_BIT, a, 1'b1};
		crc = 8'h00;
		for (int k = 15; k >= 0; k--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ msg[k]) ? 8'h07 : 8'h00);
		r = pick(9);
		chk("ara byte", msg[15:8], pick(0));
		chk("ara ack", 8'h00, {7'h0, bitLog[8]});
		chk("wire addr", {1'b0, a}, {1'b0, r[7:1]});
		chk("reply ack", {7'h0, !pec}, {7'h0, bitLog[17]});
		chk("bit count", pec ? 8'h1c : 8'h13, nBits[7:0]);
		if (pec) begin
			chk("pec byte", crc, pick(18));
			chk("last bit", 8'h01, {7'h0, bitLog[26]});
		end
	endtask

	task automatic t_alert(input addr_t a, input logic pec);
		int r = nRsp;
		int s = nSrv;
		pecEn <= pec;
		myAddr <= a;
		cyc(8);
		alertReq <= 1'b1;
		waitCnt(nRsp, r + 1);
		waitIdle();
		chkFrame(a, pec);
		chk("resp addr", {1'b0, a}, {1'b0, respAddr});
		chk("pec err", 8'h00, {7'h0, pecErr});
		chk("served", 8'(s + 1), nSrv[7:0]);
		chk("alert off", 8'h00, {7'h0, alertActive});
		chk("alert line", 8'h01, {7'h0, busIf.alertN});
		alertReq <= 1'b0;
		cyc(20);
		chk("no reread", 8'(r + 1), nRsp[7:0]);
		chk("bus idle", 8'h01, {7'h0, busIdle});
		$display("alert test done addr %h", a);
	endtask

	// Suspend asked mid frame, then an alert raised while asleep
	task automatic t_suspend();
		int r = nRsp;
		myAddr <= 7'h11;
		alertReq <= 1'b1;
		cyc(40);
		sleepReq <= 1'b1;
		cyc(300);
		chk("held in frame", 8'h01, {7'h0, busIf.suspendN});
		waitCnt(nRsp, r + 1);
		waitSus(1'b1);
		chk("sus line", 8'h00, {7'h0, busIf.suspendN});
		alertReq <= 1'b0;
		cyc(20);
		myAddr <= 7'h55;
		alertReq <= 1'b1;
		cyc(1500);
		chk("quiet", 8'(r + 1), nRsp[7:0]);
		chk("armed", 8'h01, {7'h0, alertActive});
		sleepReq <= 1'b0;
		waitSus(1'b0);
		waitCnt(nRsp, r + 2);
		chk("late addr", 8'h55, {1'b0, respAddr});
		waitIdle();
		alertReq <= 1'b0;
		cyc(20);
		$display("suspend test done");
	endtask

	task automatic t_wake();
		sleepReq <= 1'b1;
		waitSus(1'b1);
		wakeReq <= 1'b1;
		waitSus(1'b0);
		wakeReq <= 1'b0;
		waitIdle();
		chk("wake bits", 8'h01, nBits[7:0]);
		chk("wake held", 8'h01, {7'h0, busIf.suspendN});
		sleepReq <= 1'b0;
		cyc(20);
		$display("wake test done");
	endtask

	task automatic t_poll();
		int r = nNack;
		pollEn <= 1'b1;
		waitCnt(nNack, r + 1);
		pollEn <= 1'b0;
		waitIdle();
		chk("poll byte", {`SMB_ARA_ADDR, `SMB_RD_BIT}, pick(0));
		chk("no ack", 8'h01, {7'h0, bitLog[8]});
		$display("poll test done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Reset outlasts four link edges, since the device resyncs it there
	initial begin
		cycles = 0;
		nRsp = 0;
		nNack = 0;
		nSrv = 0;
		nBits = 0;
		num_errors = 0;
		check_count = 0;
		rst_n = 1'b0;
		{sleepReq, alertReq, pecEn, pollEn, wakeReq} = 5'h00;
		wakeOnStart = 1'b1;
		myAddr = 7'h00;
		cyc(8);
		rst_n <= 1'b1;
		cyc(8);
		t_alert(7'h2a, 1'b0);
		t_alert(7'h01, 1'b1);
		t_alert(7'h7f, 1'b1);
		t_suspend();
		t_wake();
		t_poll();
		report_and_stop();
	end
endmodule

`default_nettype wire
